// >>> rtl/tbpwm_pkg.sv
// Package for the six-channel buffered PWM timer: register offsets, field positions, reset values.
// Assumes a byte-wide register port with one-cycle-late read data.
package tbpwm_pkg;
    localparam int NUM_CHAN = 6;
    localparam logic [5:0] ADDR_STATUS_CTRL = 6'h00;
    localparam logic [5:0] ADDR_CNT_HI = 6'h01;
    localparam logic [5:0] ADDR_CNT_LO = 6'h02;
    localparam logic [5:0] ADDR_MOD_HI = 6'h03;
    localparam logic [5:0] ADDR_MOD_LO = 6'h04;
    // Channel x: control at base+3x, compare high at base+3x+1, compare low at base+3x+2.
    localparam logic [5:0] ADDR_CHAN_BASE = 6'h05;
    localparam logic [5:0] ADDR_BREAK_CTRL = 6'h17;
    localparam int TSC_OVF_FLAG = 7;
    localparam int TSC_OVF_IE = 6;
    localparam int TSC_HALT = 5;
    localparam int TSC_RESET = 4;
    localparam int CSC_FLAG = 7;
    localparam int CSC_IE = 6;
    localparam int CSC_UPPER = 5;
    localparam int CSC_LOWER = 4;
    localparam int CSC_ACT_HI = 3;
    localparam int CSC_ACT_LO = 2;
    localparam int CSC_TOV = 1;
    localparam int CSC_MAX = 0;
    localparam logic [7:0] TSC_RESET_VAL = 8'h20;
    localparam logic [15:0] MOD_RESET_VAL = 16'hffff;
    localparam logic [2:0] PS_EXTERNAL = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tbpwm_bus_s;
endpackage : tbpwm_pkg

// >>> rtl/tbpwm_timer.sv
// Six-channel 16-bit timer with paired buffered PWM, prescaler, external clock and flags.
// Assumes all inputs synchronous to mclk_i and a master that never issues read and write together.
`timescale 1ns/1ps
module tbpwm_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // System states
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic break_i,
    // Pins
    input wire logic ext_clk_i,
    input wire logic [5:0] chan_pin_i,
    output logic [5:0] chan_pin_o,
    output logic [5:0] chan_pin_oe_o,
    output logic ext_clk_pin_force_input_o,
    // Interrupts and wake
    output logic ovf_irq_o,
    output logic [5:0] chan_irq_o,
    output logic wake_o
);
    logic [7:0] tsc_ff;
    logic [2:0] ps_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] mod_ff;
    logic [7:0] mod_hi_buf_ff;
    logic mod_pending_ff;
    logic [6:0] pre_ff;
    logic ext_d_ff;
    logic [7:0] csc_ff [6];
    logic [CNT_W-1:0] cmp_ff [6];
    logic [7:0] cmp_hi_buf_ff [6];
    logic [5:0] out_ff;
    logic [2:0] active_odd_ff;
    logic [2:0] pending_odd_ff;
    logic [2:0] pending_set_ff;
    logic [5:0] cap_d_ff;
    logic ovf_armed_ff;
    logic [5:0] chf_armed_ff;
    logic break_clear_enable_ff;
    logic [7:0] nxt_rdata;

    logic acc_ok;
    logic wr_ok;
    logic rd_ok;
    logic tick;
    logic run;
    logic at_mod;
    logic ovf_evt;
    logic [5:0] chan_evt;
    logic [5:0] chan_linked_odd;
    logic flag_clear_ok;

    function automatic logic [1:0] mode_of(input logic [7:0] c);
        // Upper bit wins: 1x buffered, 01 unbuffered, 00 input capture.
        mode_of = c[tbpwm_pkg::CSC_UPPER] ? 2'h2 : (c[tbpwm_pkg::CSC_LOWER] ? 2'h1 : 2'h0);
    endfunction : mode_of

    function automatic logic [5:0] chan_reg_addr(input int ch, input int off);
        chan_reg_addr = 6'(int'(tbpwm_pkg::ADDR_CHAN_BASE) + 3 * ch + off);
    endfunction : chan_reg_addr

    // Registers are unreachable in wait and stop; the CPU is halted there anyway.
    assign acc_ok = !wait_mode_i && !stop_mode_i;
    assign wr_ok = wr_i && acc_ok;
    assign rd_ok = rd_i && acc_ok;
    assign flag_clear_ok = !break_i || break_clear_enable_ff;
    assign run = !tsc_ff[tbpwm_pkg::TSC_HALT] && !break_i && !stop_mode_i;
    assign at_mod = (cnt_ff == mod_ff);

    // Prescaler divides by 2^ps; the external pin is edge detected on the system clock.
    always_comb
    begin
        if (ps_ff == tbpwm_pkg::PS_EXTERNAL)
        begin
            tick = ext_clk_i && !ext_d_ff;
        end
        else if (ps_ff == 3'h0)
        begin
            tick = 1'b1;
        end
        else
        begin
            tick = (pre_ff & 7'((8'h01 << ps_ff) - 8'h01)) == 7'((8'h01 << ps_ff) - 8'h01);
        end
    end

    assign ovf_evt = run && tick && at_mod && !mod_pending_ff;
    assign ext_clk_pin_force_input_o = (ps_ff == tbpwm_pkg::PS_EXTERNAL);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre_ff <= 7'h00;
            ext_d_ff <= 1'b0;
            cnt_ff <= '0;
        end
        else
        begin
            ext_d_ff <= ext_clk_i;
            if (wr_ok && addr_i == tbpwm_pkg::ADDR_STATUS_CTRL && wdata_i[tbpwm_pkg::TSC_RESET])
            begin
                pre_ff <= 7'h00;
                cnt_ff <= '0;
            end
            else if (run)
            begin
                pre_ff <= pre_ff + 7'h01;
                if (tick)
                begin
                    cnt_ff <= at_mod ? '0 : cnt_ff + 1'b1;
                end
            end
        end
    end

    // Timer status and control, modulo and break-clear control.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tsc_ff <= tbpwm_pkg::TSC_RESET_VAL;
            ps_ff <= 3'h0;
            mod_ff <= tbpwm_pkg::MOD_RESET_VAL;
            mod_hi_buf_ff <= 8'h00;
            mod_pending_ff <= 1'b0;
            ovf_armed_ff <= 1'b0;
            break_clear_enable_ff <= 1'b0;
        end
        else
        begin
            if (rd_ok && addr_i == tbpwm_pkg::ADDR_STATUS_CTRL && tsc_ff[tbpwm_pkg::TSC_OVF_FLAG] && flag_clear_ok)
            begin
                ovf_armed_ff <= 1'b1;
            end
            if (wr_ok && addr_i == tbpwm_pkg::ADDR_STATUS_CTRL)
            begin
                tsc_ff[tbpwm_pkg::TSC_OVF_IE] <= wdata_i[tbpwm_pkg::TSC_OVF_IE];
                tsc_ff[tbpwm_pkg::TSC_HALT] <= wdata_i[tbpwm_pkg::TSC_HALT];
                ps_ff <= wdata_i[2:0];
                if (!wdata_i[tbpwm_pkg::TSC_OVF_FLAG] && ovf_armed_ff && flag_clear_ok)
                begin
                    tsc_ff[tbpwm_pkg::TSC_OVF_FLAG] <= 1'b0;
                    ovf_armed_ff <= 1'b0;
                end
            end
            if (ovf_evt)
            begin
                // A new overflow wins over a clear in the same cycle and voids the armed read.
                tsc_ff[tbpwm_pkg::TSC_OVF_FLAG] <= 1'b1;
                ovf_armed_ff <= 1'b0;
            end
            if (wr_ok && addr_i == tbpwm_pkg::ADDR_MOD_HI)
            begin
                mod_hi_buf_ff <= wdata_i;
                mod_pending_ff <= 1'b1;
            end
            if (wr_ok && addr_i == tbpwm_pkg::ADDR_MOD_LO)
            begin
                mod_ff <= CNT_W'({mod_hi_buf_ff, wdata_i});
                mod_pending_ff <= 1'b0;
            end
            if (wr_ok && addr_i == tbpwm_pkg::ADDR_BREAK_CTRL)
            begin
                break_clear_enable_ff <= wdata_i[0];
            end
        end
    end

    assign ovf_irq_o = tsc_ff[tbpwm_pkg::TSC_OVF_FLAG] && tsc_ff[tbpwm_pkg::TSC_OVF_IE];

    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_chan
            localparam int EVEN = g - (g % 2);
            localparam int PAIR = g / 2;
            logic linked;
            logic [1:0] mode;
            logic [CNT_W-1:0] cmp_sel;
            logic cmp_hit;
            logic cap_hit;

            // An odd channel whose even partner is buffered goes quiet.
            assign linked = (g % 2 == 1) && (mode_of(csc_ff[EVEN]) == 2'h2);
            assign chan_linked_odd[g] = linked;
            assign mode = mode_of(csc_ff[g]);
            if (g % 2 == 0)
            begin : g_even
                assign cmp_sel = (mode == 2'h2 && active_odd_ff[PAIR]) ? cmp_ff[g + 1] : cmp_ff[g];
            end
            else
            begin : g_odd
                assign cmp_sel = cmp_ff[g];
            end
            assign cmp_hit = run && tick && mode != 2'h0 && !linked && cnt_ff == cmp_sel;
            // Captures are ignored in break and while the counter is halted.
            assign cap_hit = run && mode == 2'h0 && !linked &&
                (csc_ff[g][tbpwm_pkg::CSC_ACT_HI] && chan_pin_i[g] && !cap_d_ff[g] ||
                 csc_ff[g][tbpwm_pkg::CSC_ACT_LO] && !chan_pin_i[g] && cap_d_ff[g]);
            assign chan_evt[g] = cmp_hit || cap_hit;

            always_ff @(posedge mclk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    csc_ff[g] <= 8'h00;
                    cmp_ff[g] <= '0;
                    cmp_hi_buf_ff[g] <= 8'h00;
                    chf_armed_ff[g] <= 1'b0;
                    out_ff[g] <= 1'b0;
                    cap_d_ff[g] <= 1'b0;
                end
                else
                begin
                    cap_d_ff[g] <= chan_pin_i[g];
                    if (rd_ok && addr_i == chan_reg_addr(g, 0) && csc_ff[g][tbpwm_pkg::CSC_FLAG] && flag_clear_ok)
                    begin
                        chf_armed_ff[g] <= 1'b1;
                    end
                    if (wr_ok && addr_i == chan_reg_addr(g, 0))
                    begin
                        csc_ff[g][6:0] <= wdata_i[6:0];
                        if (!wdata_i[tbpwm_pkg::CSC_FLAG] && chf_armed_ff[g] && flag_clear_ok)
                        begin
                            csc_ff[g][tbpwm_pkg::CSC_FLAG] <= 1'b0;
                            chf_armed_ff[g] <= 1'b0;
                        end
                    end
                    if (chan_evt[g])
                    begin
                        csc_ff[g][tbpwm_pkg::CSC_FLAG] <= 1'b1;
                        chf_armed_ff[g] <= 1'b0;
                    end
                    if (wr_ok && addr_i == chan_reg_addr(g, 1))
                    begin
                        cmp_hi_buf_ff[g] <= wdata_i;
                    end
                    if (wr_ok && addr_i == chan_reg_addr(g, 2))
                    begin
                        // Writing the active set lands at once, exactly as unbuffered PWM.
                        cmp_ff[g] <= CNT_W'({cmp_hi_buf_ff[g], wdata_i});
                    end
                    // Output: full duty wins, then compare action, then overflow toggle.
                    if (csc_ff[g][tbpwm_pkg::CSC_MAX] && csc_ff[g][tbpwm_pkg::CSC_TOV] && mode != 2'h0)
                    begin
                        out_ff[g] <= 1'b1;
                    end
                    else if (cmp_hit)
                    begin
                        if (csc_ff[g][tbpwm_pkg::CSC_ACT_HI] && csc_ff[g][tbpwm_pkg::CSC_ACT_LO])
                        begin
                            out_ff[g] <= 1'b1;
                        end
                        else if (csc_ff[g][tbpwm_pkg::CSC_ACT_HI])
                        begin
                            out_ff[g] <= 1'b0;
                        end
                        else if (csc_ff[g][tbpwm_pkg::CSC_ACT_LO])
                        begin
                            out_ff[g] <= !out_ff[g];
                        end
                    end
                    else if (ovf_evt && csc_ff[g][tbpwm_pkg::CSC_TOV] && mode != 2'h0 && !linked)
                    begin
                        out_ff[g] <= !out_ff[g];
                    end
                end
            end

            assign chan_pin_o[g] = out_ff[g];
            // A linked odd channel leaves its pin to the port logic.
            assign chan_pin_oe_o[g] = mode != 2'h0 && !linked &&
                (csc_ff[g][tbpwm_pkg::CSC_ACT_HI] || csc_ff[g][tbpwm_pkg::CSC_ACT_LO]);
            assign chan_irq_o[g] = csc_ff[g][tbpwm_pkg::CSC_FLAG] && csc_ff[g][tbpwm_pkg::CSC_IE] && !linked;
        end
    endgenerate

    // Pair hand-over: the last-written set takes over at the next overflow.
    generate
        for (g = 0; g < 3; g++)
        begin : g_pair
            always_ff @(posedge mclk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    active_odd_ff[g] <= 1'b0;
                    pending_odd_ff[g] <= 1'b0;
                    pending_set_ff[g] <= 1'b0;
                end
                else if (mode_of(csc_ff[2 * g]) != 2'h2)
                begin
                    // Unlinked pairs restart from the even set when relinked.
                    active_odd_ff[g] <= 1'b0;
                    pending_odd_ff[g] <= 1'b0;
                    pending_set_ff[g] <= 1'b0;
                end
                else
                begin
                    if (ovf_evt && pending_set_ff[g])
                    begin
                        active_odd_ff[g] <= pending_odd_ff[g];
                        pending_set_ff[g] <= 1'b0;
                    end
                    if (wr_ok && addr_i == chan_reg_addr(2 * g + 1, 2))
                    begin
                        pending_odd_ff[g] <= 1'b1;
                        pending_set_ff[g] <= 1'b1;
                    end
                    else if (wr_ok && addr_i == chan_reg_addr(2 * g, 2))
                    begin
                        pending_odd_ff[g] <= 1'b0;
                        pending_set_ff[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign wake_o = wait_mode_i && (ovf_irq_o || (|chan_irq_o));

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (addr_i == tbpwm_pkg::ADDR_STATUS_CTRL)
        begin
            nxt_rdata = {tsc_ff[7:5], 2'h0, ps_ff};
        end
        else if (addr_i == tbpwm_pkg::ADDR_CNT_HI)
        begin
            nxt_rdata = cnt_ff[15:8];
        end
        else if (addr_i == tbpwm_pkg::ADDR_CNT_LO)
        begin
            nxt_rdata = cnt_ff[7:0];
        end
        else if (addr_i == tbpwm_pkg::ADDR_MOD_HI)
        begin
            nxt_rdata = mod_ff[15:8];
        end
        else if (addr_i == tbpwm_pkg::ADDR_MOD_LO)
        begin
            nxt_rdata = mod_ff[7:0];
        end
        else if (addr_i == tbpwm_pkg::ADDR_BREAK_CTRL)
        begin
            nxt_rdata = {7'h00, break_clear_enable_ff};
        end
        for (int c = 0; c < 6; c++)
        begin
            if (addr_i == chan_reg_addr(c, 0))
            begin
                nxt_rdata = chan_linked_odd[c] ? 8'h00 : csc_ff[c];
            end
            if (addr_i == chan_reg_addr(c, 1))
            begin
                nxt_rdata = cmp_ff[c][15:8];
            end
            if (addr_i == chan_reg_addr(c, 2))
            begin
                nxt_rdata = cmp_ff[c][7:0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= rd_ok ? nxt_rdata : 8'h00;
        end
    end
endmodule : tbpwm_timer

// >>> verification/tbpwm_timer_properties.sv
// Port-level checker for the buffered PWM timer.
// Assumes it is bound to tbpwm_timer and that writes are ignored while in wait or stop.
`timescale 1ns/1ps
module tbpwm_timer_properties (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // System states
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic break_i,
    // Pins and requests
    input wire logic [5:0] chan_pin_o,
    input wire logic [5:0] chan_pin_oe_o,
    input wire logic ext_clk_pin_force_input_o,
    input wire logic ovf_irq_o,
    input wire logic [5:0] chan_irq_o,
    input wire logic wake_o
);
    // Shadows of the control bits the properties need, kept in step with the design's registers.
    logic [2:0] ps_ff;
    logic ovf_ie_ff;
    logic [7:0] ctrl0_ff;
    logic [2:0] link_ff;
    logic wr_ok;
    logic rd_blk;
    logic full0;
    logic [5:0] odd_mask;
    assign wr_ok = wr_i && !wait_mode_i && !stop_mode_i;
    assign rd_blk = rd_i && (wait_mode_i || stop_mode_i);
    assign full0 = ctrl0_ff[tbpwm_pkg::CSC_MAX] && ctrl0_ff[tbpwm_pkg::CSC_TOV] && (|ctrl0_ff[5:4]);
    assign odd_mask = {link_ff[2], 1'b0, link_ff[1], 1'b0, link_ff[0], 1'b0};

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ps_ff <= 3'h0;
            ovf_ie_ff <= 1'b0;
        end
        else if (wr_ok && addr_i == tbpwm_pkg::ADDR_STATUS_CTRL)
        begin
            ps_ff <= wdata_i[2:0];
            ovf_ie_ff <= wdata_i[tbpwm_pkg::TSC_OVF_IE];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl0_ff <= 8'h00;
            link_ff <= 3'h0;
        end
        else if (wr_ok)
        begin
            if (addr_i == tbpwm_pkg::ADDR_CHAN_BASE)
            begin
                ctrl0_ff <= wdata_i;
                link_ff[0] <= wdata_i[tbpwm_pkg::CSC_UPPER];
            end
            if (addr_i == 6'h0b)
                link_ff[1] <= wdata_i[tbpwm_pkg::CSC_UPPER];
            if (addr_i == 6'h11)
                link_ff[2] <= wdata_i[tbpwm_pkg::CSC_UPPER];
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_WAKE: assert property (wake_o == (wait_mode_i && (ovf_irq_o || (|chan_irq_o))))
        else $error("wake request does not follow wait and pending requests");
    AST_RD_BLOCKED: assert property ($past(rd_blk) |-> rdata_o == 8'h00)
        else $error("read answered while registers are inaccessible");
    AST_STOP_HOLD: assert property ($past(stop_mode_i) |-> $stable({chan_pin_o, ovf_irq_o, chan_irq_o}))
        else $error("timer state moved during stop");
    AST_BREAK_NO_OVF: assert property ($past(break_i) && !$past(wr_i) |-> !$rose(ovf_irq_o))
        else $error("overflow raised while the counter is halted");
    AST_OVF_GATED: assert property (!ovf_ie_ff |-> !ovf_irq_o)
        else $error("overflow request without enable");
    AST_CH0_GATED: assert property (!ctrl0_ff[tbpwm_pkg::CSC_IE] |-> !chan_irq_o[0])
        else $error("channel 0 request without enable");
    AST_ODD_FREE: assert property (((chan_pin_oe_o | chan_irq_o) & odd_mask) == 6'h00)
        else $error("linked odd channel still drives its pin or requests");
    AST_FULL_DUTY: assert property (full0 && $past(full0) |-> chan_pin_o[0])
        else $error("full duty output not high");
    AST_FORCE_IN: assert property (ext_clk_pin_force_input_o == (ps_ff == tbpwm_pkg::PS_EXTERNAL))
        else $error("clock pin direction does not follow source select");
    AST_OUT_EN: assert property (chan_pin_oe_o[0] == ((|ctrl0_ff[5:4]) && (|ctrl0_ff[3:2])))
        else $error("compare mode does not drive channel 0 pin");

    COV_OVF: cover property (ovf_irq_o);
    COV_WAKE: cover property (wake_o);
    COV_FULL: cover property (full0 && chan_pin_o[0]);
endmodule : tbpwm_timer_properties

bind tbpwm_timer tbpwm_timer_properties tbpwm_timer_properties_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i), .break_i(break_i), .chan_pin_o(chan_pin_o),
    .chan_pin_oe_o(chan_pin_oe_o), .ext_clk_pin_force_input_o(ext_clk_pin_force_input_o),
    .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o), .wake_o(wake_o));

// >>> verification/test_tbpwm_timer.sv
// Self-checking bench for the buffered PWM timer with random widths and corner cases.
// Assumes the checker is bound to the design and reads answer one cycle late.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module test_tbpwm_timer;
    localparam int MODV = 15;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] addr_i = 6'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic wait_mode_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic break_i = 1'b0;
    logic ext_en = 1'b0;
    logic [1:0] ext_div = 2'h0;
    logic [5:0] chan_pin_i = 6'h00;
    logic [7:0] rdata_o;
    logic [5:0] chan_pin_o;
    logic [5:0] chan_pin_oe_o;
    logic force_in;
    logic ovf_irq_o;
    logic [5:0] chan_irq_o;
    logic wake_o;
    logic prev0 = 1'b0;
    logic [7:0] rd_val;
    int error_cnt = 0;
    int checked = 0;
    int hi_c = 0, per_c = 0, last_hi = 0, last_per = 0, rises = 0;
    int base, c1, c2, n;

    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) chan_pin_i <= 6'($urandom);
    // The external clock rises every fourth system clock once enabled.
    always @(posedge mclk_i) if (ext_en) ext_div <= ext_div + 2'h1;

    tbpwm_timer tbpwm_timer_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
        .break_i(break_i), .ext_clk_i(ext_div[1]), .chan_pin_i(chan_pin_i), .chan_pin_o(chan_pin_o),
        .chan_pin_oe_o(chan_pin_oe_o), .ext_clk_pin_force_input_o(force_in), .ovf_irq_o(ovf_irq_o),
        .chan_irq_o(chan_irq_o), .wake_o(wake_o));

    // Measures high time and period of channel 0 between rising edges.
    always @(posedge mclk_i)
    begin
        if (chan_pin_o[0] === 1'b1 && prev0 === 1'b0)
        begin
            last_hi = hi_c;
            last_per = per_c;
            hi_c = 0;
            per_c = 0;
            rises++;
        end
        per_c++;
        hi_c += int'(chan_pin_o[0] === 1'b1);
        prev0 = chan_pin_o[0];
    end

    function automatic int exp_per(input int ps);
        return (ps == 7) ? (MODV + 1) * 4 : (MODV + 1) << ps;
    endfunction : exp_per

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic wr16(input logic [5:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 6'h01, d[7:0]);
    endtask : wr16

    task automatic rd(input logic [5:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rd_val = rdata_o;
    endtask : rd

    task automatic wait_rise;
        int r;
        r = rises;
        for (int i = 0; i < 2000 && rises == r; i++)
            @(posedge mclk_i);
        `CHK("pwm edge", 1'b1, 1'(rises != r))
    endtask : wait_rise

    task automatic hold_pin0(input logic v);
        repeat (40) @(posedge mclk_i);
        repeat (16)
        begin
            @(posedge mclk_i);
            #1 `CHK("pin0 level", v, chan_pin_o[0])
        end
    endtask : hold_pin0

    task automatic end_sim;
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        #300us;
        error_cnt++;
        end_sim();
    end

    initial
    begin
        n = $urandom(32'h0199);
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        `CHK("status", tbpwm_pkg::TSC_RESET_VAL, rd_val)
        rd(tbpwm_pkg::ADDR_MOD_LO);
        `CHK("modulo", 8'hff, rd_val)
        rd(6'h3f);
        `CHK("unmapped", 8'h00, rd_val)
        wr(tbpwm_pkg::ADDR_STATUS_CTRL, 8'h30);
        wr16(tbpwm_pkg::ADDR_MOD_HI, 16'(MODV));
        c1 = $urandom_range(10, 2);
        c2 = c1 + $urandom_range(3, 1);
        wr16(6'h06, 16'(c1));
        wr(6'h05, 8'h2a);
        wr(tbpwm_pkg::ADDR_STATUS_CTRL, 8'h00);
        wait_rise();
        wait_rise();
        `CHK("period", exp_per(0), last_per)
        base = last_hi;
        wait_rise();
        wr16(6'h09, 16'(c2));
        wait_rise();
        `CHK("held width", base, last_hi)
        wait_rise();
        `CHK("linked width", base + c2 - c1, last_hi)
        wr16(6'h06, 16'(c1 + 1));
        wait_rise();
        wait_rise();
        `CHK("back width", base + 1, last_hi)
        wr(6'h05, 8'h2e);
        repeat (3) wait_rise();
        `CHK("set width", exp_per(0) - base - 1, last_hi)
        wr(6'h05, 8'h28);
        hold_pin0(1'b0);
        wr(6'h05, 8'h2b);
        hold_pin0(1'b1);
        wr(6'h05, 8'h7a);
        for (int k = 1; k < 3; k++)
            wr(6'h05 + 6'(6 * k), 8'h2a);
        // The pin enables follow the control write of the last edge, so look once they have settled.
        #1;
        for (int k = 0; k < 3; k++)
        begin
            `CHK("odd pin", 1'b0, chan_pin_oe_o[2 * k + 1])
            `CHK("even pin", 1'b1, chan_pin_oe_o[2 * k])
        end
        for (int k = 1; k < 3; k++)
        begin
            wr(6'h05 + 6'(6 * k), 8'h10);
            wr(6'h08 + 6'(6 * k), 8'h18);
            #1 `CHK("unlinked odd", 1'b1, chan_pin_oe_o[2 * k + 1])
        end
        // Channel 5 captures on either edge of its random pin.
        wr(6'h14, 8'h0c);
        repeat (20) @(posedge mclk_i);
        rd(6'h14);
        `CHK("capture flag", 1'b1, rd_val[7])
        wr(6'h05, 8'h6a);
        repeat (20) @(posedge mclk_i);
        `CHK("chan irq", 1'b1, chan_irq_o[0])
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        `CHK("ovf flag", 1'b1, rd_val[7])
        `CHK("ovf masked", 1'b0, ovf_irq_o)
        wr(tbpwm_pkg::ADDR_STATUS_CTRL, 8'h40);
        repeat (20) @(posedge mclk_i);
        `CHK("ovf irq", 1'b1, ovf_irq_o)
        wait_mode_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 `CHK("wake", 1'b1, wake_o)
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        `CHK("wait read", 8'h00, rd_val)
        wait_rise();
        wait_mode_i <= 1'b0;
        @(posedge mclk_i);
        stop_mode_i <= 1'b1;
        n = rises;
        repeat (60) @(posedge mclk_i);
        `CHK("stop frozen", n, rises)
        stop_mode_i <= 1'b0;
        wait_rise();
        break_i <= 1'b1;
        rd(tbpwm_pkg::ADDR_CNT_LO);
        n = rd_val;
        repeat (5) @(posedge mclk_i);
        rd(tbpwm_pkg::ADDR_CNT_LO);
        `CHK("break count", 8'(n), rd_val)
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        wr(tbpwm_pkg::ADDR_STATUS_CTRL, 8'h40);
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        `CHK("flag kept", 1'b1, rd_val[7])
        wr(tbpwm_pkg::ADDR_BREAK_CTRL, 8'h01);
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        wr(tbpwm_pkg::ADDR_STATUS_CTRL, 8'h40);
        rd(tbpwm_pkg::ADDR_STATUS_CTRL);
        `CHK("flag cleared", 1'b0, rd_val[7])
        break_i <= 1'b0;
        wr(tbpwm_pkg::ADDR_BREAK_CTRL, 8'h00);
        for (int p = 1; p < 8; p++)
        begin
            wr(tbpwm_pkg::ADDR_STATUS_CTRL, 8'(p));
            ext_en <= (p == 7);
            repeat (3) wait_rise();
            `CHK("scaled period", exp_per(p), last_per)
            `CHK("clock pin input", 1'(p == 7), force_in)
        end
        end_sim();
    end
endmodule : test_tbpwm_timer
